// *** design/ucc_top.sv ***
// Control and configuration registers of a UART with their side effects.
// Assumes the serial core reports events as one-cycle pulses on CLK and
// status flags as levels; all inputs are synchronous to CLK.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Behaviour
// - Word length bit selects nine or eight data bits
// - Ninth bit stored on receive, sourced on transmit
// - Power down takes effect after current byte
// - Wake method: idle line or address mark
// - Parity enable applies after current byte
// - Parity odd select applies after current byte
// - Parity error interrupt when enabled
// - Buffer empty and complete interrupts when enabled
// - Receive/overrun and idle interrupts when enabled
// - Transmitter starts one bit time after enable
// - Enable toggle while busy sends idle preamble
// - Receive enable starts start bit search
// - Mute set by software, cleared on wakeup
// - Mute write ignored with address wake, buffer full
// - Break sent, cleared at break stop bit
// - Stop code decoded, 01 reserved
// - Clock pin enable, idle level, capture phase
// - Last data bit clock pulse select
// - Four bit node address for wakeup
// - DMA requests per direction when enabled
// - Smartcard mode and parity error NAK
// - Half duplex, infrared and infrared low power
// - Error interrupt only with DMA receive
// - Interrupts gated by global mask
module ucc_top (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire ucc_pkg::ucc_status_s STATUS,
	input wire ucc_pkg::ucc_evt_s EVT,
	input wire logic GLOBAL_MASK,
	output ucc_pkg::ucc_cfg_s CFG,
	output logic IRQ_TX,
	output logic IRQ_RX,
	output logic DMA_TX_REQ,
	output logic DMA_RX_REQ,
	output logic NAK_REQ
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] frame_r;
	logic [7:0] irqen_r;
	logic [7:0] stopck_r;
	logic [7:0] node_r;
	logic [7:0] mode_r;
	logic [7:0] rdata_nxt;
	logic wr_frame;
	logic wr_irqen;
	logic wr_stopck;
	logic wr_node;
	logic wr_mode;
	logic line_idle;
	logic byte_edge;
	logic wake_hit;
	logic mute_wr_ok;
	logic tx_en_prev_r;
	logic tx_wait_r;
	logic preamble_pend_r;
	logic [2:0] stop_half_nxt;
	logic par_en_r, par_odd_r, power_down_r;
	logic tx_run_r, send_preamble_r;
	logic word_nine_r, tx_ninth_r, wake_addr_r;
	logic rx_search_r, mute_r, send_break_r;
	logic [2:0] stop_half_r;
	logic clk_pin_en_r, clk_idle_level_r, clk_phase_r, last_pulse_r;
	logic [3:0] node_id_r;
	logic smartcard_r, half_duplex_r, ir_en_r, ir_low_power_r;

	// Write decodes
	assign wr_frame = WR && (ADDR == ucc_pkg::OFS_FRAME);
	assign wr_irqen = WR && (ADDR == ucc_pkg::OFS_IRQEN);
	assign wr_stopck = WR && (ADDR == ucc_pkg::OFS_STOPCK);
	assign wr_node = WR && (ADDR == ucc_pkg::OFS_NODE);
	assign wr_mode = WR && (ADDR == ucc_pkg::OFS_MODE);

	// Byte boundary: between frames or at the end of a word
	assign line_idle = !EVT.tx_busy && !EVT.rx_busy;
	assign byte_edge = line_idle || EVT.tx_word_done || EVT.rx_word_done;

	// Wakeup recognition for the selected method
	always_comb begin
		if (frame_r[ucc_pkg::B_WAKE_ADDR]) begin
			wake_hit = EVT.addr_mark && (EVT.addr == node_r[3:0]);
		end else begin
			wake_hit = EVT.idle_seen;
		end
	end

	// Mute bit is locked with address wake while a word waits
	assign mute_wr_ok = !(frame_r[ucc_pkg::B_WAKE_ADDR] && STATUS.rx_buffer_full);

	// ----------------------------------------
	// Frame control register
	// ----------------------------------------
	// Ninth received bit loads at word end; hardware load beats software
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			frame_r <= ucc_pkg::RST_CTRL;
		end else begin
			if (wr_frame) begin
				frame_r <= WDATA;
			end
			if (EVT.rx_word_done && frame_r[ucc_pkg::B_WORD_NINE]) begin
				frame_r[ucc_pkg::B_RX_NINTH] <= EVT.rx_ninth;
			end
		end
	end

	// ----------------------------------------
	// Interrupt and enable register
	// ----------------------------------------
	// Mute and break bits have hardware clears; a software set wins
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			irqen_r <= ucc_pkg::RST_CTRL;
		end else begin
			if (wr_irqen) begin
				irqen_r[7:2] <= WDATA[7:2];
				irqen_r[ucc_pkg::B_BREAK] <= WDATA[ucc_pkg::B_BREAK];
			end
			if (wr_irqen && mute_wr_ok) begin
				irqen_r[ucc_pkg::B_MUTE] <= WDATA[ucc_pkg::B_MUTE];
			end
			if (wake_hit && !(wr_irqen && mute_wr_ok && WDATA[ucc_pkg::B_MUTE])) begin
				irqen_r[ucc_pkg::B_MUTE] <= 1'b0;
			end
			if (EVT.break_stop && !(wr_irqen && WDATA[ucc_pkg::B_BREAK])) begin
				irqen_r[ucc_pkg::B_BREAK] <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Stop, clock, node and mode registers
	// ----------------------------------------
	// Reserved bits are masked off on write
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			stopck_r <= ucc_pkg::RST_CTRL;
			node_r <= ucc_pkg::RST_CTRL;
			mode_r <= ucc_pkg::RST_CTRL;
		end else begin
			if (wr_stopck) begin
				stopck_r <= WDATA & ucc_pkg::MASK_STOPCK;
			end
			if (wr_node) begin
				node_r <= WDATA & ucc_pkg::MASK_NODE;
			end
			if (wr_mode) begin
				mode_r <= WDATA;
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped offsets read zero
	always_comb begin
		case (ADDR)
			ucc_pkg::OFS_FRAME: rdata_nxt = frame_r;
			ucc_pkg::OFS_IRQEN: rdata_nxt = irqen_r;
			ucc_pkg::OFS_STOPCK: rdata_nxt = stopck_r;
			ucc_pkg::OFS_NODE: rdata_nxt = node_r;
			ucc_pkg::OFS_MODE: rdata_nxt = mode_r;
			default: rdata_nxt = 8'h00;
		endcase
	end

	// Read data stand one cycle after the strobe, zero otherwise
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			RDATA <= 8'h00;
		end else begin
			RDATA <= RD ? rdata_nxt : 8'h00;
		end
	end

	// ----------------------------------------
	// Transmitter start and preamble
	// ----------------------------------------
	// Start waits one bit tick after the enable rises
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tx_en_prev_r <= 1'b0;
			tx_wait_r <= 1'b0;
		end else begin
			tx_en_prev_r <= irqen_r[ucc_pkg::B_TX_EN];
			if (!irqen_r[ucc_pkg::B_TX_EN]) begin
				tx_wait_r <= 1'b0;
			end else if (!tx_en_prev_r) begin
				tx_wait_r <= 1'b1;
			end else if (EVT.bit_tick) begin
				tx_wait_r <= 1'b0;
			end
		end
	end

	// A disable-enable pulse during a word queues an idle preamble
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			preamble_pend_r <= 1'b0;
		end else if (irqen_r[ucc_pkg::B_TX_EN] && !tx_en_prev_r && EVT.tx_busy) begin
			preamble_pend_r <= 1'b1;
		end else if (EVT.tx_word_done) begin
			preamble_pend_r <= 1'b0;
		end
	end

	// Stop count decode; reserved code falls back to one stop bit
	always_comb begin
		case (stopck_r[ucc_pkg::B_STOP_HI:ucc_pkg::B_STOP_LO])
			ucc_pkg::STOP_ONE: stop_half_nxt = ucc_pkg::HALF_ONE;
			ucc_pkg::STOP_TWO: stop_half_nxt = ucc_pkg::HALF_TWO;
			ucc_pkg::STOP_ONE_HALF: stop_half_nxt = ucc_pkg::HALF_ONE_HALF;
			default: stop_half_nxt = ucc_pkg::HALF_ONE;
		endcase
	end

	// ----------------------------------------
	// Configuration toward the serial core
	// ----------------------------------------
	// Parity and power down settle only on a byte boundary
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			par_en_r <= 1'b0;
			par_odd_r <= 1'b0;
			power_down_r <= 1'b0;
		end else if (byte_edge) begin
			par_en_r <= frame_r[ucc_pkg::B_PAR_EN];
			par_odd_r <= frame_r[ucc_pkg::B_PAR_ODD];
			power_down_r <= frame_r[ucc_pkg::B_PWR_DOWN];
		end
	end

	// Transmitter run and preamble request
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tx_run_r <= 1'b0;
			send_preamble_r <= 1'b0;
		end else begin
			tx_run_r <= irqen_r[ucc_pkg::B_TX_EN] && tx_en_prev_r && !tx_wait_r;
			if (preamble_pend_r && EVT.tx_word_done) begin
				send_preamble_r <= 1'b1;
			end else if (EVT.preamble_done) begin
				send_preamble_r <= 1'b0;
			end
		end
	end

	// Plain copies of the remaining fields, except the stop length, which is registered from its decode
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			word_nine_r <= 1'b0;
			tx_ninth_r <= 1'b0;
			wake_addr_r <= 1'b0;
			rx_search_r <= 1'b0;
			mute_r <= 1'b0;
			send_break_r <= 1'b0;
			stop_half_r <= ucc_pkg::HALF_ONE;
			clk_pin_en_r <= 1'b0;
			clk_idle_level_r <= 1'b0;
			clk_phase_r <= 1'b0;
			last_pulse_r <= 1'b0;
			node_id_r <= 4'h0;
			smartcard_r <= 1'b0;
			half_duplex_r <= 1'b0;
			ir_en_r <= 1'b0;
			ir_low_power_r <= 1'b0;
		end else begin
			word_nine_r <= frame_r[ucc_pkg::B_WORD_NINE];
			tx_ninth_r <= frame_r[ucc_pkg::B_TX_NINTH];
			wake_addr_r <= frame_r[ucc_pkg::B_WAKE_ADDR];
			rx_search_r <= irqen_r[ucc_pkg::B_RX_EN];
			mute_r <= irqen_r[ucc_pkg::B_MUTE];
			send_break_r <= irqen_r[ucc_pkg::B_BREAK];
			stop_half_r <= stop_half_nxt;
			clk_pin_en_r <= stopck_r[ucc_pkg::B_CLK_EN];
			clk_idle_level_r <= stopck_r[ucc_pkg::B_CLK_POL];
			clk_phase_r <= stopck_r[ucc_pkg::B_CLK_PHA];
			last_pulse_r <= stopck_r[ucc_pkg::B_LAST_PULSE];
			node_id_r <= node_r[3:0];
			smartcard_r <= mode_r[ucc_pkg::B_SC_EN];
			half_duplex_r <= mode_r[ucc_pkg::B_HALF_DUP];
			ir_en_r <= mode_r[ucc_pkg::B_IR_EN];
			ir_low_power_r <= mode_r[ucc_pkg::B_IR_LP];
		end
	end

	// Configuration word packed from its registers; one driver per field, no logic between
	always_comb begin
		CFG.word_nine = word_nine_r;
		CFG.tx_ninth = tx_ninth_r;
		CFG.power_down = power_down_r;
		CFG.wake_addr = wake_addr_r;
		CFG.par_en = par_en_r;
		CFG.par_odd = par_odd_r;
		CFG.tx_run = tx_run_r;
		CFG.rx_search = rx_search_r;
		CFG.mute = mute_r;
		CFG.send_break = send_break_r;
		CFG.send_preamble = send_preamble_r;
		CFG.stop_half = stop_half_r;
		CFG.clk_pin_en = clk_pin_en_r;
		CFG.clk_idle_level = clk_idle_level_r;
		CFG.clk_phase = clk_phase_r;
		CFG.last_pulse = last_pulse_r;
		CFG.node_id = node_id_r;
		CFG.smartcard = smartcard_r;
		CFG.half_duplex = half_duplex_r;
		CFG.ir_en = ir_en_r;
		CFG.ir_low_power = ir_low_power_r;
	end

	// ----------------------------------------
	// Interrupt, DMA and NAK requests
	// ----------------------------------------
	// Interrupts are held off by the global mask; power down does not gate them
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			IRQ_TX <= 1'b0;
			IRQ_RX <= 1'b0;
		end else begin
			IRQ_TX <= !GLOBAL_MASK && (
				(irqen_r[ucc_pkg::B_TXE_IE] && STATUS.tx_buffer_empty) ||
				(irqen_r[ucc_pkg::B_TC_IE] && STATUS.tc));
			IRQ_RX <= !GLOBAL_MASK && (
				(irqen_r[ucc_pkg::B_RX_IE] && (STATUS.ovr || STATUS.rx_buffer_full)) ||
				(irqen_r[ucc_pkg::B_IDLE_IE] && STATUS.idle) ||
				(frame_r[ucc_pkg::B_PAR_IE] && STATUS.pe) ||
				(mode_r[ucc_pkg::B_ERR_IE] && mode_r[ucc_pkg::B_DMA_RX] &&
				(STATUS.fe || STATUS.ovr || STATUS.nf)));
		end
	end

	// DMA requests follow the buffer flags; NAK pulses on a parity error
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			DMA_TX_REQ <= 1'b0;
			DMA_RX_REQ <= 1'b0;
			NAK_REQ <= 1'b0;
		end else begin
			DMA_TX_REQ <= mode_r[ucc_pkg::B_DMA_TX] && STATUS.tx_buffer_empty && !power_down_r;
			DMA_RX_REQ <= mode_r[ucc_pkg::B_DMA_RX] && STATUS.rx_buffer_full && !power_down_r;
			NAK_REQ <= mode_r[ucc_pkg::B_SC_EN] && mode_r[ucc_pkg::B_SC_NAK] &&
				EVT.pe_event;
		end
	end
endmodule

// *** pkg/ucc_pkg.sv ***
// Package of the UART control block: offsets, field positions, resets, carriers.
// Assumes a byte-wide register port with a four-bit address.
package ucc_pkg;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [3:0] OFS_FRAME = 4'h4;
	localparam logic [3:0] OFS_IRQEN = 4'h5;
	localparam logic [3:0] OFS_STOPCK = 4'h6;
	localparam logic [3:0] OFS_NODE = 4'h7;
	localparam logic [3:0] OFS_MODE = 4'h8;
	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] MASK_STOPCK = 8'h3F;
	localparam logic [7:0] MASK_NODE = 8'h0F;
	// ----------------------------------------
	// Field positions, frame_control
	// ----------------------------------------
	localparam int B_RX_NINTH = 7;
	localparam int B_TX_NINTH = 6;
	localparam int B_PWR_DOWN = 5;
	localparam int B_WORD_NINE = 4;
	localparam int B_WAKE_ADDR = 3;
	localparam int B_PAR_EN = 2;
	localparam int B_PAR_ODD = 1;
	localparam int B_PAR_IE = 0;
	// ----------------------------------------
	// Field positions, irq_and_enable_control
	// ----------------------------------------
	localparam int B_TXE_IE = 7;
	localparam int B_TC_IE = 6;
	localparam int B_RX_IE = 5;
	localparam int B_IDLE_IE = 4;
	localparam int B_TX_EN = 3;
	localparam int B_RX_EN = 2;
	localparam int B_MUTE = 1;
	localparam int B_BREAK = 0;
	// ----------------------------------------
	// Field positions, stop_and_sync_clock_control
	// ----------------------------------------
	localparam int B_STOP_HI = 5;
	localparam int B_STOP_LO = 4;
	localparam int B_CLK_EN = 3;
	localparam int B_CLK_POL = 2;
	localparam int B_CLK_PHA = 1;
	localparam int B_LAST_PULSE = 0;
	// ----------------------------------------
	// Field positions, mode_and_dma_control
	// ----------------------------------------
	localparam int B_DMA_TX = 7;
	localparam int B_DMA_RX = 6;
	localparam int B_SC_EN = 5;
	localparam int B_SC_NAK = 4;
	localparam int B_HALF_DUP = 3;
	localparam int B_IR_LP = 2;
	localparam int B_IR_EN = 1;
	localparam int B_ERR_IE = 0;
	// ----------------------------------------
	// Stop count codes and lengths in half bits
	// ----------------------------------------
	localparam logic [1:0] STOP_ONE = 2'h0;
	localparam logic [1:0] STOP_TWO = 2'h2;
	localparam logic [1:0] STOP_ONE_HALF = 2'h3;
	localparam logic [2:0] HALF_ONE = 3'h2;
	localparam logic [2:0] HALF_TWO = 3'h4;
	localparam logic [2:0] HALF_ONE_HALF = 3'h3;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic tx_buffer_empty;
		logic tc;
		logic rx_buffer_full;
		logic idle;
		logic ovr;
		logic nf;
		logic fe;
		logic pe;
	} ucc_status_s;
	typedef struct packed {
		logic bit_tick;
		logic tx_busy;
		logic rx_busy;
		logic tx_word_done;
		logic rx_word_done;
		logic rx_ninth;
		logic break_stop;
		logic preamble_done;
		logic idle_seen;
		logic addr_mark;
		logic [3:0] addr;
		logic pe_event;
	} ucc_evt_s;
	typedef struct packed {
		logic word_nine;
		logic tx_ninth;
		logic power_down;
		logic wake_addr;
		logic par_en;
		logic par_odd;
		logic tx_run;
		logic rx_search;
		logic mute;
		logic send_break;
		logic send_preamble;
		logic [2:0] stop_half;
		logic clk_pin_en;
		logic clk_idle_level;
		logic clk_phase;
		logic last_pulse;
		logic [3:0] node_id;
		logic smartcard;
		logic half_duplex;
		logic ir_en;
		logic ir_low_power;
	} ucc_cfg_s;
endpackage

// *** bench/ucc_properties.sv ***
// Checker of the UART control block, watching the top ports only.
// Assumes it is bound to ucc_top and shares its clock and reset.
`timescale 1ns/1ps
module ucc_properties (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	input wire logic [7:0] RDATA,
	input wire ucc_pkg::ucc_status_s STATUS,
	input wire ucc_pkg::ucc_evt_s EVT,
	input wire logic GLOBAL_MASK,
	input wire ucc_pkg::ucc_cfg_s CFG,
	input wire logic IRQ_TX,
	input wire logic IRQ_RX,
	input wire logic DMA_TX_REQ,
	input wire logic DMA_RX_REQ,
	input wire logic NAK_REQ
);
	logic [7:0] frm_r, ien_r, stp_r, mod_r;
	logic [2:0] stop_exp;
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// Shadows of bits that only software changes
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			frm_r <= 8'h00;
			ien_r <= 8'h00;
			stp_r <= 8'h00;
			mod_r <= 8'h00;
		end else if (WR) begin
			if (ADDR == ucc_pkg::OFS_FRAME) frm_r <= WDATA;
			if (ADDR == ucc_pkg::OFS_IRQEN) ien_r <= WDATA;
			if (ADDR == ucc_pkg::OFS_STOPCK) stp_r <= WDATA;
			if (ADDR == ucc_pkg::OFS_MODE) mod_r <= WDATA;
		end
	end
	// Stop length expected from the code
	always_comb begin
		case (stp_r[5:4])
			2'h2: stop_exp = ucc_pkg::HALF_TWO;
			2'h3: stop_exp = ucc_pkg::HALF_ONE_HALF;
			default: stop_exp = ucc_pkg::HALF_ONE;
		endcase
	end
	a_unmapped_zero: assert property (
		RD && (ADDR < ucc_pkg::OFS_FRAME || ADDR > ucc_pkg::OFS_MODE) |=> RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_reserved_zero: assert property (
		RD && ADDR == ucc_pkg::OFS_NODE |=> RDATA[7:4] == 4'h0)
		else $error("reserved node bits not zero");
	a_stop_code: assert property (CFG.stop_half == $past(stop_exp))
		else $error("stop length wrong");
	a_tx_masked: assert property (GLOBAL_MASK |=> !IRQ_TX)
		else $error("tx interrupt while masked");
	a_tc_irq: assert property (
		!GLOBAL_MASK && STATUS.tc && ien_r[ucc_pkg::B_TC_IE] |=> IRQ_TX)
		else $error("complete interrupt missing");
	a_par_irq: assert property (
		!GLOBAL_MASK && STATUS.pe && frm_r[ucc_pkg::B_PAR_IE] |=> IRQ_RX)
		else $error("parity interrupt missing");
	a_dma_tx: assert property (
		mod_r[7] && STATUS.tx_buffer_empty && !CFG.power_down && !frm_r[5] |=> DMA_TX_REQ)
		else $error("dma tx request missing");
	a_nak_pulse: assert property (
		NAK_REQ == $past(EVT.pe_event && mod_r[5] && mod_r[4]))
		else $error("nak request wrong");
	a_break_clear: assert property (
		EVT.break_stop && !(WR && ADDR == ucc_pkg::OFS_IRQEN && WDATA[0])
		|=> (WR && ADDR == ucc_pkg::OFS_IRQEN && WDATA[0]) or (##1 !CFG.send_break))
		else $error("break not cleared");
	a_tx_start: assert property ($rose(CFG.tx_run) |-> $past(EVT.bit_tick, 2))
		else $error("transmitter started off a bit tick");
	c_nak: cover property (NAK_REQ);
	c_tx_run: cover property ($rose(CFG.tx_run));
	c_irq_both: cover property (IRQ_RX && IRQ_TX);
endmodule
bind ucc_top ucc_properties u_ucc_properties (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .STATUS(STATUS), .EVT(EVT),
	.GLOBAL_MASK(GLOBAL_MASK), .CFG(CFG), .IRQ_TX(IRQ_TX), .IRQ_RX(IRQ_RX),
	.DMA_TX_REQ(DMA_TX_REQ), .DMA_RX_REQ(DMA_RX_REQ), .NAK_REQ(NAK_REQ));

// *** bench/ucc_core_model.sv ***
// Model of the serial core facing the control block.
// Assumes the bench supplies flag levels and event requests on clk.
`timescale 1ns/1ps
module ucc_core_model (
	input wire logic clk,
	input wire logic resetn,
	input wire ucc_pkg::ucc_status_s st_in,
	input wire ucc_pkg::ucc_evt_s req,
	output ucc_pkg::ucc_status_s status,
	output ucc_pkg::ucc_evt_s evt
);
	logic [1:0] div_r;
	// Bit time of four clocks, free running
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_r <= 2'h0;
		end else begin
			div_r <= div_r + 2'h1;
		end
	end
	// Busy levels forwarded so frame settings stay put mid word
	always_comb begin
		evt = req;
		evt.bit_tick = (div_r == 2'h3);
	end
	assign status = st_in;
endmodule

// *** bench/ucc_top_tb.sv ***
// Testbench of the UART control block against a register model.
// Assumes ucc_top, the core model and the bound checker are compiled.
`timescale 1ns/1ps
module ucc_top_tb;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic gmask = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic irq_tx, irq_rx, dma_tx, dma_rx, nak;
	ucc_pkg::ucc_status_s st = '0;
	ucc_pkg::ucc_status_s status;
	ucc_pkg::ucc_evt_s req = '0;
	ucc_pkg::ucc_evt_s hold = '0;
	ucc_pkg::ucc_evt_s ev;
	ucc_pkg::ucc_evt_s evt;
	ucc_pkg::ucc_cfg_s cfg;
	logic [2:0] half [4] = '{ucc_pkg::HALF_ONE, ucc_pkg::HALF_ONE, ucc_pkg::HALF_TWO,
		ucc_pkg::HALF_ONE_HALF};
	int mdl [16] = '{default: 0};
	int err_count = 0;
	int samples_checked = 0;
	always #2.5 clk = ~clk;
	ucc_core_model u_ucc_core_model (.clk(clk), .resetn(resetn), .st_in(st), .req(req),
		.status(status), .evt(evt));
	ucc_top u_ucc_top (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .STATUS(status), .EVT(evt), .GLOBAL_MASK(gmask), .CFG(cfg),
		.IRQ_TX(irq_tx), .IRQ_RX(irq_rx), .DMA_TX_REQ(dma_tx), .DMA_RX_REQ(dma_rx), .NAK_REQ(nak));
	// Compare one result and count it
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("Error %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Register write, model updated with masks and the mute lock
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		if (a == 4'h5 && mdl[4][3] && st.rx_buffer_full) d[1] = mdl[5][1];
		case (a)
			4'h4, 4'h5, 4'h8: mdl[a] = d;
			4'h6: mdl[a] = d & ucc_pkg::MASK_STOPCK;
			4'h7: mdl[a] = d & ucc_pkg::MASK_NODE;
			default: ;
		endcase
	endtask
	// Register read, data looked at in the slot after the strobe
	task automatic rd_chk(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(rdata, mdl[a][7:0], "read");
	endtask
	// One-cycle core event over the held levels
	task automatic pulse(input ucc_pkg::ucc_evt_s e);
		@(posedge clk);
		req <= e | hold;
		@(posedge clk);
		req <= hold;
	endtask
	// Expected interrupt and DMA levels
	function automatic logic [3:0] outs_exp();
		logic [7:0] f, i, m;
		logic t, r;
		f = mdl[4];
		i = mdl[5];
		m = mdl[8];
		t = !gmask && (st.tx_buffer_empty && i[7] || st.tc && i[6]);
		r = !gmask && (i[5] && (st.rx_buffer_full || st.ovr) || i[4] && st.idle || f[0] && st.pe
			|| m[0] && m[6] && (st.fe || st.ovr || st.nf));
		return {t, r, m[7] && st.tx_buffer_empty, m[6] && st.rx_buffer_full};
	endfunction
	task automatic complete_run();
		if (err_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#50000;
		err_count++;
		complete_run();
	end
	// Main sequence
	initial begin
		void'($urandom(32'hc7e5));
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		for (int a = 3; a < 10; a++) rd_chk(4'(a));
		for (int a = 3; a < 10; a++) begin
			wr_reg(4'(a), 8'($urandom));
			rd_chk(4'(a));
		end
		// Plain configuration copies against the register model
		chk({1'b0, cfg.tx_ninth, 1'b0, cfg.word_nine, cfg.wake_addr, 3'h0},
			8'(mdl[4]) & 8'h58, "frame");
		chk({5'h00, cfg.rx_search, cfg.mute, cfg.send_break},
			8'(mdl[5]) & 8'h07, "enable");
		chk({4'h0, cfg.clk_pin_en, cfg.clk_idle_level, cfg.clk_phase, cfg.last_pulse},
			8'(mdl[6]) & 8'h0F, "clock");
		chk({4'h0, cfg.node_id}, 8'(mdl[7]), "node");
		chk({2'h0, cfg.smartcard, 1'b0, cfg.half_duplex, cfg.ir_low_power, cfg.ir_en, 1'b0},
			8'(mdl[8]) & 8'h2E, "mode");
		for (int k = 0; k < 40; k++) begin
			wr_reg(4'h4, 8'($urandom) & 8'h17);
			wr_reg(4'h5, 8'($urandom) & 8'hF0);
			wr_reg(4'h8, 8'($urandom));
			st <= ucc_pkg::ucc_status_s'(8'($urandom));
			gmask <= 1'($urandom);
			repeat (3) @(posedge clk);
			@(negedge clk);
			chk({4'h0, irq_tx, irq_rx, dma_tx, dma_rx}, {4'h0, outs_exp()}, "irq");
		end
		st <= ucc_pkg::ucc_status_s'(8'h20);
		gmask <= 1'b0;
		wr_reg(4'h4, 8'h08);
		wr_reg(4'h5, 8'h02);
		rd_chk(4'h5);
		st <= '0;
		wr_reg(4'h7, 8'h15);
		wr_reg(4'h5, 8'h02);
		ev = '0;
		ev.addr_mark = 1'b1;
		ev.addr = 4'h3;
		pulse(ev);
		rd_chk(4'h5);
		ev.addr = 4'h5;
		pulse(ev);
		mdl[5][1] = 0;
		rd_chk(4'h5);
		wr_reg(4'h4, 8'h10);
		wr_reg(4'h5, 8'h02);
		ev = '0;
		ev.idle_seen = 1'b1;
		ev.rx_word_done = 1'b1;
		ev.rx_ninth = 1'b1;
		pulse(ev);
		mdl[5][1] = 0;
		mdl[4][7] = 1;
		rd_chk(4'h5);
		rd_chk(4'h4);
		wr_reg(4'h5, 8'h01);
		ev = '0;
		ev.break_stop = 1'b1;
		pulse(ev);
		mdl[5][0] = 0;
		rd_chk(4'h5);
		wr_reg(4'h8, 8'h30);
		ev = '0;
		ev.pe_event = 1'b1;
		pulse(ev);
		@(negedge clk);
		chk(8'(nak), 8'h01, "nak");
		for (int c = 0; c < 4; c++) begin
			wr_reg(4'h6, 8'(c << 4));
			repeat (2) @(posedge clk);
			@(negedge clk);
			chk(8'(cfg.stop_half), 8'(half[c]), "stop");
		end
		hold.tx_busy = 1'b1;
		pulse('0);
		wr_reg(4'h4, 8'h26);
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(8'({cfg.power_down, cfg.par_en, cfg.par_odd}), 8'h00, "defer");
		wr_reg(4'h5, 8'h08);
		ev = '0;
		ev.tx_word_done = 1'b1;
		pulse(ev);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(8'({cfg.power_down, cfg.par_en, cfg.par_odd}), 8'h07, "apply");
		chk(8'(cfg.send_preamble), 8'h01, "preamble");
		hold = '0;
		ev = '0;
		ev.preamble_done = 1'b1;
		pulse(ev);
		wr_reg(4'h5, 8'h00);
		repeat (4) @(posedge clk);
		wr_reg(4'h5, 8'h08);
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(8'(cfg.tx_run), 8'h00, "early start");
		// Bit tick comes every four clocks, so the start is due within four more cycles
		for (int n = 0; n < 4 && cfg.tx_run !== 1'b1; n++) @(negedge clk);
		chk(8'(cfg.tx_run), 8'h01, "start");
		complete_run();
	end
endmodule
